// ===== pkg/eqcl_pkg.sv
// package for the equalizer coefficient load sequencer: offsets, layouts,
// reset values and the coefficient store geometry.
// assumes a byte-wide control-port register access at printed offsets.
package eqcl_pkg;
  localparam logic [15:0] EQCL_OFS_IN0   = 16'h2401;
  localparam logic [15:0] EQCL_OFS_IN1   = 16'h2402;
  localparam logic [15:0] EQCL_OFS_IN2   = 16'h2403;
  localparam logic [15:0] EQCL_OFS_IN3   = 16'h2404;
  localparam logic [15:0] EQCL_OFS_OUT0  = 16'h2407;
  localparam logic [15:0] EQCL_OFS_OUT1  = 16'h2408;
  localparam logic [15:0] EQCL_OFS_OUT2  = 16'h2409;
  localparam logic [15:0] EQCL_OFS_OUT3  = 16'h240A;
  localparam logic [15:0] EQCL_OFS_ACC   = 16'h2410;
  localparam logic [15:0] EQCL_OFS_START = 16'h2411;
  localparam logic [15:0] EQCL_OFS_MUTE  = 16'h2412;
  localparam int          EQCL_BIT_READ  = 0;
  localparam int          EQCL_BIT_WRITE = 1;
  localparam int          EQCL_NCOEF     = 15;
  localparam int          EQCL_PER_BQ    = 5;
  localparam logic [3:0]  EQCL_IDX_RST   = 4'h0;
  localparam logic [2:0]  EQCL_POS_RST   = 3'h0;
  localparam logic [31:0] EQCL_COEF_ONE  = 32'h7FFFFFFF;
  localparam logic [31:0] EQCL_COEF_ZERO = 32'h00000000;
  localparam logic [7:0]  EQCL_REG_RST   = 8'h00;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } eqcl_req_s;
endpackage

// ===== verilog/eqcl_seq.sv
// coefficient load sequencer: byte registers, access gating, store of the
// fifteen biquad coefficients, freeze while running, and bus stretch.
// assumes a control-port agent that holds a request while STALL is high.
`timescale 1ns/1ps
module eqcl_seq
  import eqcl_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire eqcl_req_s   REQ,
  input  wire logic        EQ_POWER_DOWN,
  output logic             STALL,
  output logic [7:0]       RDATA,
  output logic             FILTER_RUN,
  output logic             EQ_INPUT_MUTE,
  output logic [32*EQCL_NCOEF-1:0] COEFS
);
  logic [7:0]  in_q [3];
  logic [31:0] coef_q [EQCL_NCOEF];
  logic [3:0]  wr_idx_q;
  logic [3:0]  rd_idx_q;
  logic [31:0] rd_hold_q;
  logic        wen_q;
  logic        ren_q;
  logic        run_q;
  logic        mute_q;
  logic        read_seen_q;
  logic [7:0]  rdata_q;
  logic        legal;
  logic        wr_top;
  logic        rd_low;
  logic        stop_reset;

  // exactly one enable and powered up, else stretch
  assign legal  = !EQ_POWER_DOWN && (wen_q ^ ren_q);
  assign wr_top = REQ.wr && REQ.addr == EQCL_OFS_IN3;
  assign rd_low = REQ.rd && REQ.addr == EQCL_OFS_OUT0;
  assign STALL  = (wr_top || rd_low) && !legal;
  // start falling after a readback wipes to pass-through
  assign stop_reset = REQ.wr && REQ.addr == EQCL_OFS_START
                      && !REQ.wdata[0] && run_q && read_seen_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      wen_q  <= 1'b0;
      ren_q  <= 1'b0;
      run_q  <= 1'b0;
      mute_q <= 1'b0;
    end else if (REQ.wr) begin
      if (REQ.addr == EQCL_OFS_ACC) begin
        wen_q <= REQ.wdata[EQCL_BIT_WRITE];
        ren_q <= REQ.wdata[EQCL_BIT_READ];
      end
      if (REQ.addr == EQCL_OFS_START)
        run_q <= REQ.wdata[0];
      if (REQ.addr == EQCL_OFS_MUTE)
        mute_q <= REQ.wdata[0];
    end
  end

  // low three bytes only park; the top byte completes the word
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < 3; i++)
        in_q[i] <= EQCL_REG_RST;
    end else if (REQ.wr) begin
      if (REQ.addr == EQCL_OFS_IN0)
        in_q[0] <= REQ.wdata;
      if (REQ.addr == EQCL_OFS_IN1)
        in_q[1] <= REQ.wdata;
      if (REQ.addr == EQCL_OFS_IN2)
        in_q[2] <= REQ.wdata;
    end
  end

  // store; frozen while running, wraps after fifteen commits
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_idx_q <= EQCL_IDX_RST;
      for (int i = 0; i < EQCL_NCOEF; i++)
        coef_q[i] <= (i % EQCL_PER_BQ == 0) ? EQCL_COEF_ONE
                                            : EQCL_COEF_ZERO;
    end else if (stop_reset) begin
      wr_idx_q <= EQCL_IDX_RST;
      for (int i = 0; i < EQCL_NCOEF; i++)
        coef_q[i] <= (i % EQCL_PER_BQ == 0) ? EQCL_COEF_ONE
                                            : EQCL_COEF_ZERO;
    end else if (wr_top && legal && wen_q && !run_q) begin
      coef_q[wr_idx_q] <= {REQ.wdata, in_q[2], in_q[1], in_q[0]};
      wr_idx_q <= (wr_idx_q == 4'(EQCL_NCOEF - 1)) ? EQCL_IDX_RST
                                                  : wr_idx_q + 4'h1;
    end else if (REQ.wr && REQ.addr == EQCL_OFS_ACC) begin
      wr_idx_q <= EQCL_IDX_RST;
    end
  end

  // readback: low byte snapshots the next slot, upper bytes from snapshot
  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_idx_q    <= EQCL_IDX_RST;
      rd_hold_q   <= EQCL_COEF_ZERO;
      rdata_q     <= EQCL_REG_RST;
      read_seen_q <= 1'b0;
    end else begin
      if (REQ.wr && REQ.addr == EQCL_OFS_ACC)
        rd_idx_q <= EQCL_IDX_RST;
      // only a real commit or the wipe itself ends the readback window; a refused top byte
      // while running leaves the pending wipe armed
      if (stop_reset || (wr_top && legal && wen_q && !run_q))
        read_seen_q <= 1'b0;
      if (rd_low && legal && ren_q) begin
        rd_hold_q   <= coef_q[rd_idx_q];
        rdata_q     <= coef_q[rd_idx_q][7:0];
        read_seen_q <= 1'b1;
        rd_idx_q    <= (rd_idx_q == 4'(EQCL_NCOEF - 1)) ? EQCL_IDX_RST
                                                       : rd_idx_q + 4'h1;
      end else if (REQ.rd) begin
        unique case (REQ.addr)
          EQCL_OFS_OUT1:  rdata_q <= rd_hold_q[15:8];
          EQCL_OFS_OUT2:  rdata_q <= rd_hold_q[23:16];
          EQCL_OFS_OUT3:  rdata_q <= rd_hold_q[31:24];
          EQCL_OFS_ACC:   rdata_q <= {6'h00, wen_q, ren_q};
          EQCL_OFS_START: rdata_q <= {7'h00, run_q};
          EQCL_OFS_MUTE:  rdata_q <= {7'h00, mute_q};
          default:        rdata_q <= EQCL_REG_RST;
        endcase
      end
    end
  end

  assign RDATA         = rdata_q;
  assign FILTER_RUN    = run_q;
  assign EQ_INPUT_MUTE = mute_q;
  always_comb begin
    for (int i = 0; i < EQCL_NCOEF; i++)
      COEFS[32*i +: 32] = coef_q[i];
  end
endmodule

// ===== tb/eqcl_checker.sv
// checker: bus stretch, control bits and store stability of eqcl_seq.
// assumes it is bound to eqcl_seq by the bind at the foot of this file.
`timescale 1ns/1ps
module eqcl_checker
  import eqcl_pkg::*;
(
  input wire logic                     CLK,
  input wire logic                     RST,
  input wire eqcl_req_s                REQ,
  input wire logic                     EQ_POWER_DOWN,
  input wire logic                     STALL,
  input wire logic                     FILTER_RUN,
  input wire logic                     EQ_INPUT_MUTE,
  input wire logic [32*EQCL_NCOEF-1:0] COEFS
);
  logic [1:0] en_q;
  wire        ok = !EQ_POWER_DOWN && ^en_q;
  wire        tw = REQ.wr && REQ.addr == EQCL_OFS_IN3;
  wire        lr = REQ.rd && REQ.addr == EQCL_OFS_OUT0;
  wire        sw = REQ.wr && REQ.addr == EQCL_OFS_START;
  // access control writes are never stretched, so no stall term here
  always_ff @(posedge CLK)
    if (RST) en_q <= 2'h0;
    else if (REQ.wr && REQ.addr == EQCL_OFS_ACC) en_q <= REQ.wdata[1:0];
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_stall_top:
    assert property (tw |-> STALL == !ok) else $error("top byte stall");
  a_stall_low:
    assert property (lr |-> STALL == !ok) else $error("low byte stall");
  a_stall_none:
    assert property (!tw && !lr |-> !STALL) else $error("stray stall");
  a_start_bit:
    assert property (sw |=> FILTER_RUN == $past(REQ.wdata[0]))
      else $error("start bit");
  a_mute_bit:
    assert property (REQ.wr && REQ.addr == EQCL_OFS_MUTE
      |=> EQ_INPUT_MUTE == $past(REQ.wdata[0])) else $error("mute bit");
  a_run_frozen:
    assert property (FILTER_RUN && tw |=> $stable(COEFS)) else $error("frz");
  a_no_commit:
    assert property (!tw && !sw |=> $stable(COEFS)) else $error("commit");
  a_stall_hold:
    assert property (tw && !ok |=> $stable(COEFS)) else $error("stall wr");
endmodule
bind eqcl_seq eqcl_checker chk_u(.CLK(CLK), .RST(RST), .REQ(REQ),
  .EQ_POWER_DOWN(EQ_POWER_DOWN), .STALL(STALL), .FILTER_RUN(FILTER_RUN),
  .EQ_INPUT_MUTE(EQ_INPUT_MUTE), .COEFS(COEFS));

// ===== tb/eqcl_host.sv
// host model on the control port: byte transfers and stall probes.
// assumes the device holds off a request by raising STALL.
`timescale 1ns/1ps
module eqcl_host
  import eqcl_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       STALL,
  input  wire logic [7:0] RDATA,
  output eqcl_req_s       REQ
);
  logic hung = 1'h0;
  initial REQ = '0;
  // idle bus shows inverted address and data so stale values never match
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge CLK) REQ <= {w, ~w, a, d};
    @(posedge CLK);
    while (STALL === 1'h1 && n < 20) begin
      n++;
      @(posedge CLK);
    end
    hung <= hung | (n == 20);
    REQ <= {2'h0, ~a, ~d};
    #1 q = RDATA;
  endtask
  task automatic probe(input logic w, input logic [15:0] a, output logic s);
    @(posedge CLK) REQ <= {w, ~w, a, 8'h00};
    @(posedge CLK) #1 s = STALL;
    @(posedge CLK) REQ <= {2'h0, ~a, 8'hFF};
  endtask
endmodule

// ===== tb/eqcl_seq_tb_top.sv
// testbench: load, stall, readback, run and wipe sequences on eqcl_seq.
// assumes the host model and the bound checker.
`timescale 1ns/1ps
module eqcl_seq_tb_top
  import eqcl_pkg::*;
;
  logic                     clk = 1'h0, rst = 1'h1, pdn = 1'h0;
  logic                     stall, run, mute, s;
  logic [7:0]               rdata, q;
  eqcl_req_s                req;
  logic [32*EQCL_NCOEF-1:0] coefs;
  int                       miscompares = 0, n_tests = 0;
  initial forever #10 clk = ~clk;
  eqcl_seq dut_u(.CLK(clk), .RST(rst), .REQ(req), .EQ_POWER_DOWN(pdn),
    .STALL(stall), .RDATA(rdata), .FILTER_RUN(run), .EQ_INPUT_MUTE(mute),
    .COEFS(coefs));
  eqcl_host host_u(.CLK(clk), .STALL(stall), .RDATA(rdata), .REQ(req));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("compares=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] cv(input int i);
    return 32'h11223344 ^ {4{i[7:0]}};
  endfunction
  // pass-through: b0 of each biquad at +1.0, all else zero
  task automatic cc(input logic p);
    for (int i = 0; i < EQCL_NCOEF; i++)
      chk(coefs[32*i+:32], p ? (i % 5 ? EQCL_COEF_ZERO : EQCL_COEF_ONE) : cv(i));
  endtask
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    host_u.xfer(1'h1, a, d, q);
  endtask
  always @(posedge clk) if (host_u.hung) begin
    miscompares++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    cc(1'h1);
    w(EQCL_OFS_MUTE, 8'h01);
    chk(mute, 1'h1);
    w(EQCL_OFS_ACC, 8'h02);
    for (int i = 0; i < EQCL_NCOEF; i++)
      for (int b = 0; b < 4; b++) w(EQCL_OFS_IN0 + b, 8'(cv(i) >> 8*b));
    cc(1'h0);
    w(EQCL_OFS_ACC, 8'h03);
    host_u.probe(1'h1, EQCL_OFS_IN3, s);
    chk(s, 1'h1);
    w(EQCL_OFS_ACC, 8'h00);
    host_u.probe(1'h0, EQCL_OFS_OUT0, s);
    chk(s, 1'h1);
    @(posedge clk) pdn <= 1'h1;
    w(EQCL_OFS_ACC, 8'h01);
    host_u.probe(1'h0, EQCL_OFS_OUT0, s);
    chk(s, 1'h1);
    @(posedge clk) pdn <= 1'h0;
    w(EQCL_OFS_ACC, 8'h01);
    for (int b = 0; b < 4; b++) begin
      host_u.xfer(1'h0, EQCL_OFS_OUT0 + b, 8'h00, q);
      chk(q, 8'(cv(0) >> 8*b));
    end
    w(EQCL_OFS_ACC, 8'h00);
    w(EQCL_OFS_START, 8'h01);
    chk(run, 1'h1);
    w(EQCL_OFS_ACC, 8'h02);
    for (int b = 0; b < 4; b++) w(EQCL_OFS_IN0 + b, 8'hEE);
    cc(1'h0);
    w(EQCL_OFS_ACC, 8'h00);
    w(EQCL_OFS_START, 8'h00);
    cc(1'h1);
    w(EQCL_OFS_START, 8'h01);
    cc(1'h1);
    w(EQCL_OFS_MUTE, 8'h00);
    chk(mute, 1'h0);
    results();
  end
endmodule
